//--- sub_unit_pkg.sv
// constants, types and register map for the subtract execution unit
// Function
// - width_select 0 gives 32-bit data and 1 gives 64-bit data, the width being 32 shifted left by that bit.
// - in the extended-register form an extend_shift_amount above four marks the instruction undefined.
// - extend option codes 000 to 011 zero-extend byte, halfword, word, doubleword; 100 to 111 sign-extend them.
// - the extended second operand is shifted left by extend_shift_amount (0 to 4) before subtracting.
// - the difference is first operand plus inverted second operand plus a carry-in of one, with no flags.
// - a first_source_index of 31 takes the first operand from the low data-width bits of the stack pointer.
// - a destination index of 31 writes the zero-extended result to the stack pointer, else the general register.
// - in the extended-register form a second_source_index of 31 reads the zero_register, value zero.
// - in the 64-bit extended form the second source is a 64-bit read only for option codes x11, else 32-bit.
// - the immediate form zero-extends twelve_bit_immediate, shifted left by 12 when immediate_shift_select is 1.
// - twelve_bit_immediate is an unsigned value from 0 to 4095.
// - with data_independent_timing_flag set, execution time does not depend on operand or flag values.
// - with data_independent_timing_flag set, exception response does not depend on operand or flag values.
package sub_unit_pkg;

  // ************************************************
  // datapath
  // ************************************************
  localparam int DATA_W = 64;
  localparam int IDX_W = 5;
  localparam int NARROW_W = 32;
  localparam logic [IDX_W-1:0] SP_INDEX = 5'h1f;
  localparam logic [2:0] MAX_EXT_SHIFT = 3'h4;
  localparam int IMM_SHIFT = 12;
  localparam int LATENCY = 2;
  localparam logic [DATA_W-1:0] NARROW_MASK = 64'h0000_0000_ffff_ffff;

  // ************************************************
  // register map
  // ************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] MASK_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] COUNT_OFFSET = 8'h0c;
  localparam logic [ADDR_W-1:0] RESULT_LO_OFFSET = 8'h10;
  localparam logic [ADDR_W-1:0] RESULT_HI_OFFSET = 8'h14;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_DIT_BIT = 1;
  localparam int EVT_DONE_BIT = 0;
  localparam int EVT_UNDEF_BIT = 1;
  localparam int EVT_W = 2;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [EVT_W-1:0] MASK_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************
  // bus states
  // ************************************************
  typedef enum logic [0:0] {WR_IDLE = 1'b0, WR_RESP = 1'b1} wr_state_t;
  typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_DATA = 1'b1} rd_state_t;

endpackage

//--- operand_former.sv
// second operand forming: extension, shift and immediate
`timescale 1ns/10ps
module operand_former #(
  parameter int DATA_W = 64,
  parameter int IMM_W = 12
) (
  // selection
  input wire logic immediate_form,
  input wire logic width_select,
  input wire logic [2:0] extend_option,
  input wire logic [2:0] extend_shift_amount,
  input wire logic [4:0] second_source_index,
  input wire logic [IMM_W-1:0] twelve_bit_immediate,
  input wire logic immediate_shift_select,
  // value
  input wire logic [DATA_W-1:0] second_source_value,
  output logic [DATA_W-1:0] operand
);
  import sub_unit_pkg::*;

  logic [DATA_W-1:0] reg_value;
  logic [DATA_W-1:0] extended;
  logic [DATA_W-1:0] shifted;
  logic [DATA_W-1:0] imm_value;
  logic [DATA_W-1:0] width_mask;
  logic sign_ext;

  assign sign_ext = extend_option[2];
  assign width_mask = width_select ? {DATA_W{1'b1}} : NARROW_MASK;

  // zero register, then 32- or 64-bit read
  assign reg_value = (second_source_index == SP_INDEX) ? '0 :
                     (extend_option[1:0] == 2'b11) ? second_source_value :
                     (second_source_value & NARROW_MASK);

  // ************************************************
  // extension by size and sign
  // ************************************************
  always_comb
  begin
    case (extend_option[1:0])
      2'b00: extended = {{(DATA_W-8){sign_ext & reg_value[7]}}, reg_value[7:0]};
      2'b01: extended = {{(DATA_W-16){sign_ext & reg_value[15]}}, reg_value[15:0]};
      2'b10: extended = {{(DATA_W-32){sign_ext & reg_value[31]}}, reg_value[31:0]};
      default: extended = reg_value;
    endcase
  end

  assign shifted = extended << extend_shift_amount;
  // unsigned immediate, optionally moved up
  assign imm_value = immediate_shift_select ?
                     {{(DATA_W-IMM_W-IMM_SHIFT){1'b0}}, twelve_bit_immediate, {IMM_SHIFT{1'b0}}} :
                     {{(DATA_W-IMM_W){1'b0}}, twelve_bit_immediate};
  assign operand = (immediate_form ? imm_value : shifted) & width_mask;

endmodule // operand_former

//--- subtract_extended_immediate_unit.sv
// subtract execution unit with axi4-lite control and status
`timescale 1ns/10ps
module subtract_extended_immediate_unit #(
  parameter int DATA_W = 64,
  parameter int IMM_W = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // issue
  input wire logic issue_valid,
  output logic issue_ready,
  input wire logic immediate_form,
  input wire logic width_select,
  input wire logic [2:0] extend_option,
  input wire logic [2:0] extend_shift_amount,
  input wire logic [IMM_W-1:0] twelve_bit_immediate,
  input wire logic immediate_shift_select,
  input wire logic [sub_unit_pkg::IDX_W-1:0] first_source_index,
  input wire logic [sub_unit_pkg::IDX_W-1:0] second_source_index,
  input wire logic [sub_unit_pkg::IDX_W-1:0] dest_index,
  input wire logic [DATA_W-1:0] first_source_value,
  input wire logic [DATA_W-1:0] second_source_value,
  input wire logic [DATA_W-1:0] stack_pointer_value,
  // write-back
  output logic wb_valid,
  output logic wb_write_enable,
  output logic wb_to_stack_pointer,
  output logic wb_undefined,
  output logic [sub_unit_pkg::IDX_W-1:0] wb_dest_index,
  output logic [DATA_W-1:0] wb_result,
  // interrupt
  output logic irq,
  // axi4-lite write
  input wire logic [sub_unit_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [sub_unit_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sub_unit_pkg::*;

  // ************************************************
  // declarations
  // ************************************************
  logic [1:0] ctrl_reg;
  logic [1:0] ctrl_next;
  logic [EVT_W-1:0] status_reg;
  logic [EVT_W-1:0] status_next;
  logic [EVT_W-1:0] mask_reg;
  logic [EVT_W-1:0] mask_next;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic [DATA_W-1:0] last_reg;
  logic [DATA_W-1:0] last_next;

  logic s1_valid_reg;
  logic s1_undef_reg;
  logic s1_width_reg;
  logic [IDX_W-1:0] s1_dest_reg;
  logic [DATA_W-1:0] s1_op1_reg;
  logic [DATA_W-1:0] s1_op2_reg;

  logic wb_valid_reg;
  logic wb_write_reg;
  logic wb_sp_reg;
  logic wb_undef_reg;
  logic [IDX_W-1:0] wb_dest_reg;
  logic [DATA_W-1:0] wb_result_reg;

  wr_state_t wr_state_reg;
  wr_state_t wr_state_next;
  rd_state_t rd_state_reg;
  rd_state_t rd_state_next;
  logic aw_have_reg;
  logic w_have_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic w_strb0_reg;
  logic [1:0] bresp_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // ************************************************
  // issue and operand selection
  // ************************************************
  wire issue_fire;
  wire [DATA_W-1:0] width_mask;
  wire [DATA_W-1:0] op1_value;
  wire [DATA_W-1:0] op2_value;
  wire issue_undef;
  wire [DATA_W-1:0] difference;
  wire [DATA_W-1:0] result_value;

  assign issue_ready = ctrl_reg[CTRL_ENABLE_BIT];
  assign issue_fire = issue_valid & issue_ready;
  assign width_mask = width_select ? {DATA_W{1'b1}} : NARROW_MASK;
  assign op1_value = ((first_source_index == SP_INDEX) ? stack_pointer_value :
                      first_source_value) & width_mask;
  assign issue_undef = ~immediate_form & (extend_shift_amount > MAX_EXT_SHIFT);

  operand_former #(
    .DATA_W(DATA_W),
    .IMM_W(IMM_W)
  ) u_operand_former (
    .immediate_form(immediate_form),
    .width_select(width_select),
    .extend_option(extend_option),
    .extend_shift_amount(extend_shift_amount),
    .second_source_index(second_source_index),
    .twelve_bit_immediate(twelve_bit_immediate),
    .immediate_shift_select(immediate_shift_select),
    .second_source_value(second_source_value),
    .operand(op2_value)
  );

  // ************************************************
  // stage one: captured operands
  // ************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_valid_reg <= 1'b0;
      s1_undef_reg <= 1'b0;
      s1_width_reg <= 1'b0;
      s1_dest_reg <= '0;
      s1_op1_reg <= '0;
      s1_op2_reg <= '0;
    end
    else
    begin
      s1_valid_reg <= issue_fire;
      s1_undef_reg <= issue_undef;
      s1_width_reg <= width_select;
      s1_dest_reg <= dest_index;
      s1_op1_reg <= op1_value;
      s1_op2_reg <= op2_value;
    end
  end

  // ************************************************
  // stage two: carry-in adder, no flags
  // ************************************************
  // one adder path for every operand value; no early exit
  assign difference = s1_op1_reg + ~s1_op2_reg + {{(DATA_W-1){1'b0}}, 1'b1};
  assign result_value = difference & (s1_width_reg ? {DATA_W{1'b1}} : NARROW_MASK);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wb_valid_reg <= 1'b0;
      wb_write_reg <= 1'b0;
      wb_sp_reg <= 1'b0;
      wb_undef_reg <= 1'b0;
      wb_dest_reg <= '0;
      wb_result_reg <= '0;
    end
    else
    begin
      wb_valid_reg <= s1_valid_reg;
      wb_write_reg <= s1_valid_reg & ~s1_undef_reg;
      wb_sp_reg <= s1_valid_reg & ~s1_undef_reg & (s1_dest_reg == SP_INDEX);
      wb_undef_reg <= s1_valid_reg & s1_undef_reg;
      wb_dest_reg <= s1_dest_reg;
      wb_result_reg <= result_value;
    end
  end

  assign wb_valid = wb_valid_reg;
  assign wb_write_enable = wb_write_reg;
  assign wb_to_stack_pointer = wb_sp_reg;
  assign wb_undefined = wb_undef_reg;
  assign wb_dest_index = wb_dest_reg;
  assign wb_result = wb_result_reg;

  // ************************************************
  // events, counter and interrupt
  // ************************************************
  wire [EVT_W-1:0] events;
  wire write_do;
  wire [ADDR_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire wr_strb0;
  wire wr_ctrl;
  wire wr_status;
  wire wr_mask;
  wire wr_hit;

  assign events = {s1_valid_reg & s1_undef_reg, s1_valid_reg & ~s1_undef_reg};
  // set beats clear in the same cycle
  assign status_next = (status_reg & ~((wr_status & wr_strb0) ? wr_data[EVT_W-1:0] : '0)) | events;
  assign ctrl_next = (wr_ctrl & wr_strb0) ? wr_data[1:0] : ctrl_reg;
  assign mask_next = (wr_mask & wr_strb0) ? wr_data[EVT_W-1:0] : mask_reg;
  assign count_next = events[EVT_DONE_BIT] ? count_reg + 32'h1 : count_reg;
  assign last_next = events[EVT_DONE_BIT] ? result_value : last_reg;
  assign irq = |(status_reg & mask_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= CTRL_RESET;
      status_reg <= '0;
      mask_reg <= MASK_RESET;
      count_reg <= '0;
      last_reg <= '0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      count_reg <= count_next;
      last_reg <= last_next;
    end
  end

  // ************************************************
  // axi4-lite write channel
  // ************************************************
  wire aw_take;
  wire w_take;
  wire aw_now;
  wire w_now;

  assign s_axi_awready = (wr_state_reg == WR_IDLE) & ~aw_have_reg;
  assign s_axi_wready = (wr_state_reg == WR_IDLE) & ~w_have_reg;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign aw_now = aw_have_reg | aw_take;
  assign w_now = w_have_reg | w_take;
  assign write_do = (wr_state_reg == WR_IDLE) & aw_now & w_now;
  assign wr_addr = aw_have_reg ? aw_addr_reg : s_axi_awaddr;
  assign wr_data = w_have_reg ? w_data_reg : s_axi_wdata;
  assign wr_strb0 = w_have_reg ? w_strb0_reg : s_axi_wstrb[0];
  assign wr_ctrl = write_do & (wr_addr == CTRL_OFFSET);
  assign wr_status = write_do & (wr_addr == STATUS_OFFSET);
  assign wr_mask = write_do & (wr_addr == MASK_OFFSET);
  assign wr_hit = wr_ctrl | wr_status | wr_mask;

  always_comb
  begin
    wr_state_next = wr_state_reg;
    case (wr_state_reg)
      WR_IDLE:
        if (write_do)
          wr_state_next = WR_RESP;
      WR_RESP:
        if (s_axi_bready)
          wr_state_next = WR_IDLE;
      default:
        wr_state_next = WR_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state_reg <= WR_IDLE;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb0_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else
    begin
      wr_state_reg <= wr_state_next;
      aw_have_reg <= aw_now & ~write_do;
      w_have_reg <= w_now & ~write_do;
      if (aw_take)
        aw_addr_reg <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb0_reg <= s_axi_wstrb[0];
      end
      if (write_do)
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  assign s_axi_bvalid = (wr_state_reg == WR_RESP);
  assign s_axi_bresp = bresp_reg;

  // ************************************************
  // axi4-lite read channel
  // ************************************************
  wire ar_take;
  wire rd_ctrl;
  wire rd_status;
  wire rd_mask;
  wire rd_count;
  wire rd_lo;
  wire rd_hi;
  wire rd_hit;
  wire [31:0] rd_value;

  assign s_axi_arready = (rd_state_reg == RD_IDLE);
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rd_ctrl = (s_axi_araddr == CTRL_OFFSET);
  assign rd_status = (s_axi_araddr == STATUS_OFFSET);
  assign rd_mask = (s_axi_araddr == MASK_OFFSET);
  assign rd_count = (s_axi_araddr == COUNT_OFFSET);
  assign rd_lo = (s_axi_araddr == RESULT_LO_OFFSET);
  assign rd_hi = (s_axi_araddr == RESULT_HI_OFFSET);
  assign rd_hit = rd_ctrl | rd_status | rd_mask | rd_count | rd_lo | rd_hi;
  assign rd_value = rd_ctrl ? {30'h0, ctrl_reg} :
                    rd_status ? {30'h0, status_reg} :
                    rd_mask ? {30'h0, mask_reg} :
                    rd_count ? count_reg :
                    rd_lo ? last_reg[31:0] :
                    rd_hi ? last_reg[DATA_W-1:32] :
                    32'h0;

  always_comb
  begin
    rd_state_next = rd_state_reg;
    case (rd_state_reg)
      RD_IDLE:
        if (ar_take)
          rd_state_next = RD_DATA;
      RD_DATA:
        if (s_axi_rready)
          rd_state_next = RD_IDLE;
      default:
        rd_state_next = RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_reg <= RD_IDLE;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end
    else
    begin
      rd_state_reg <= rd_state_next;
      if (ar_take)
      begin
        rdata_reg <= rd_value;
        rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_rvalid = (rd_state_reg == RD_DATA);
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule // subtract_extended_immediate_unit

//--- sub_unit_checker.sv
// port assertions for the subtract execution unit
`timescale 1ns/10ps
module sub_unit_checker #(
  parameter int DATA_W = 64,
  parameter int IMM_W = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // issue
  input wire logic issue_valid,
  input wire logic issue_ready,
  input wire logic immediate_form,
  input wire logic width_select,
  input wire logic [2:0] extend_shift_amount,
  input wire logic [IMM_W-1:0] twelve_bit_immediate,
  input wire logic immediate_shift_select,
  input wire logic [4:0] first_source_index,
  input wire logic [4:0] second_source_index,
  input wire logic [4:0] dest_index,
  input wire logic [DATA_W-1:0] first_source_value,
  input wire logic [DATA_W-1:0] stack_pointer_value,
  // write-back
  input wire logic wb_valid,
  input wire logic wb_write_enable,
  input wire logic wb_to_stack_pointer,
  input wire logic wb_undefined,
  input wire logic [4:0] wb_dest_index,
  input wire logic [DATA_W-1:0] wb_result,
  // interrupt and bus
  input wire logic irq,
  input wire logic s_axi_bvalid
);
  import sub_unit_pkg::*;
  logic take, defined;
  assign take = issue_valid && issue_ready;
  assign defined = immediate_form || (extend_shift_amount <= MAX_EXT_SHIFT);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ************************************************
  // assertions
  // ************************************************
  fixed_latency_a: assert property (take |-> ##2 wb_valid)
    else $error("late write-back");
  no_stray_wb_a: assert property (wb_valid |-> $past(take, 2))
    else $error("stray write-back");
  undef_shift_a: assert property (take && !defined |-> ##2 wb_undefined && !wb_write_enable)
    else $error("shift not undefined");
  defined_op_a: assert property (take && defined |-> ##2 !wb_undefined && wb_write_enable)
    else $error("op not written");
  sp_dest_a: assert property (take && defined |-> ##2 wb_dest_index == $past(dest_index, 2)
    && wb_to_stack_pointer == (wb_dest_index == SP_INDEX))
    else $error("bad destination");
  narrow_res_a: assert property (take && !width_select |-> ##2 wb_result[DATA_W-1:NARROW_W] == '0)
    else $error("narrow upper half set");
  imm_sub_a: assert property (take && immediate_form && width_select && !immediate_shift_select
    && first_source_index != SP_INDEX |-> ##2 wb_result == $past(first_source_value, 2) - $past(twelve_bit_immediate, 2))
    else $error("bad immediate result");
  zero_reg_a: assert property (take && !immediate_form && defined && width_select
    && second_source_index == SP_INDEX && first_source_index != SP_INDEX
    |-> ##2 wb_result == $past(first_source_value, 2))
    else $error("zero register not zero");
  sp_source_a: assert property (take && immediate_form && width_select && first_source_index == SP_INDEX
    && twelve_bit_immediate == '0 |-> ##2 wb_result == $past(stack_pointer_value, 2))
    else $error("bad stack pointer operand");
  irq_cause_a: assert property ($rose(irq) |-> wb_valid || s_axi_bvalid)
    else $error("stray interrupt");
  cover property (take && immediate_form);
  cover property (wb_undefined);
  cover property (irq);
endmodule // sub_unit_checker
bind subtract_extended_immediate_unit sub_unit_checker #(.DATA_W(DATA_W), .IMM_W(IMM_W)) i_chk (
  .aclk, .aresetn, .issue_valid, .issue_ready, .immediate_form, .width_select, .extend_shift_amount,
  .twelve_bit_immediate, .immediate_shift_select, .first_source_index, .second_source_index, .dest_index,
  .first_source_value, .stack_pointer_value, .wb_valid, .wb_write_enable, .wb_to_stack_pointer, .wb_undefined,
  .wb_dest_index, .wb_result, .irq, .s_axi_bvalid
);

//--- reg_file_model.sv
// register file and stack pointer model beside the subtract unit
`timescale 1ns/10ps
module reg_file_model (
  // clock
  input wire logic aclk,
  // read side
  input wire logic [4:0] first_source_index,
  input wire logic [4:0] second_source_index,
  output logic [63:0] first_source_value,
  output logic [63:0] second_source_value,
  output logic [63:0] stack_pointer_value,
  // write-back side
  input wire logic wb_write_enable,
  input wire logic wb_to_stack_pointer,
  input wire logic [4:0] wb_dest_index,
  input wire logic [63:0] wb_result
);
  logic [63:0] regs [0:31];
  logic [63:0] sp;
  // live value at index 31 shows a missed zero register
  initial
  begin
    for (int i = 0; i < 32; i++)
      regs[i] = 64'h9e37_79b9_7f4a_7c15 * 64'(i + 1);
    sp = 64'h8123_4567_89ab_cdef;
  end
  assign first_source_value = regs[first_source_index];
  assign second_source_value = regs[second_source_index];
  assign stack_pointer_value = sp;
  always @(posedge aclk)
  begin
    if (wb_write_enable && wb_to_stack_pointer)
      sp <= wb_result;
    else if (wb_write_enable)
      regs[wb_dest_index] <= wb_result;
  end
endmodule // reg_file_model

//--- test_subtract_extended_immediate_unit.sv
// self-checking bench for the subtract execution unit
`timescale 1ns/10ps
module test_subtract_extended_immediate_unit;
  import sub_unit_pkg::*;
  typedef struct packed {logic imf; logic ws; logic [2:0] opt; logic [2:0] sa; logic [11:0] imm;
    logic ish; logic [4:0] fi; logic [4:0] si; logic [4:0] di;} op_t;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic issue_valid = 1'h0;
  op_t fld = '0;
  logic immediate_form, width_select, immediate_shift_select, issue_ready, irq;
  logic [2:0] extend_option, extend_shift_amount;
  logic [11:0] twelve_bit_immediate;
  logic [4:0] first_source_index, second_source_index, dest_index, wb_dest_index;
  logic [63:0] first_source_value, second_source_value, stack_pointer_value, wb_result;
  logic wb_valid, wb_write_enable, wb_to_stack_pointer, wb_undefined;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [63:0] last_res = 64'h0;
  int err_total = 0, cmp_count = 0, def_cnt = 0;
  op_t spec [10] = '{'{1'h0, 1'h1, 3'h3, 3'h2, 12'h0, 1'h0, 5'h4, 5'h1f, 5'h6},
    '{1'h0, 1'h0, 3'h7, 3'h1, 12'h0, 1'h0, 5'h1f, 5'h5, 5'h1f}, '{1'h0, 1'h1, 3'h6, 3'h4, 12'h0, 1'h0, 5'h1f, 5'ha, 5'h1f},
    '{1'h0, 1'h1, 3'h0, 3'h5, 12'h0, 1'h0, 5'h1, 5'h2, 5'h3}, '{1'h0, 1'h0, 3'h4, 3'h6, 12'h0, 1'h0, 5'h2, 5'h3, 5'h4},
    '{1'h0, 1'h0, 3'h1, 3'h7, 12'h0, 1'h0, 5'h3, 5'h4, 5'h1f}, '{1'h1, 1'h1, 3'h0, 3'h7, 12'hfff, 1'h0, 5'h3, 5'h0, 5'h8},
    '{1'h1, 1'h0, 3'h0, 3'h0, 12'hfff, 1'h1, 5'h1f, 5'h0, 5'h1f}, '{1'h1, 1'h1, 3'h0, 3'h0, 12'h0, 1'h0, 5'h1f, 5'h0, 5'h2},
    '{1'h1, 1'h1, 3'h0, 3'h0, 12'h800, 1'h1, 5'h7, 5'h1f, 5'h1f}};
  assign {immediate_form, width_select, extend_option, extend_shift_amount, twelve_bit_immediate,
    immediate_shift_select, first_source_index, second_source_index, dest_index} = fld;
  always #4 aclk = ~aclk;
  subtract_extended_immediate_unit i_dut (.aclk, .aresetn, .issue_valid, .issue_ready, .immediate_form,
    .width_select, .extend_option, .extend_shift_amount, .twelve_bit_immediate, .immediate_shift_select,
    .first_source_index, .second_source_index, .dest_index, .first_source_value, .second_source_value,
    .stack_pointer_value, .wb_valid, .wb_write_enable, .wb_to_stack_pointer, .wb_undefined, .wb_dest_index,
    .wb_result, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  reg_file_model i_rf (.aclk, .first_source_index, .second_source_index, .first_source_value, .second_source_value,
    .stack_pointer_value, .wb_write_enable, .wb_to_stack_pointer, .wb_dest_index, .wb_result);
  // ************************************************
  // tasks
  // ************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic reg_io(input logic wr, input logic [7:0] ad, input logic [31:0] d, input logic [31:0] e,
    input logic [1:0] er);
    logic pa = 1'h1, pr = 1'h1, pw, ga, gw, gr;
    int t = 0;
    pw = wr;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_araddr <= ad;
    s_axi_wdata <= d;
    while (1'h1)
    begin
      s_axi_awvalid <= wr && pa;
      s_axi_arvalid <= !wr && pa;
      s_axi_wvalid <= pw;
      s_axi_bready <= wr && pr;
      s_axi_rready <= !wr && pr;
      if (!pr || t > 63)
        break;
      @(negedge aclk);
      ga = pa && (wr ? s_axi_awready : s_axi_arready);
      gw = pw && s_axi_wready;
      gr = wr ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      rs = wr ? s_axi_bresp : s_axi_rresp;
      t++;
      @(posedge aclk);
      pa = pa && !ga;
      pw = pw && !gw;
      pr = pr && !gr;
    end
    check(64'(pr), 64'h0);
    check(64'(rs), 64'(er));
    if (!wr)
      check(64'(q), 64'(e));
  endtask
  task automatic do_op(input op_t o);
    logic [63:0] a, b, m, e;
    logic und;
    int n;
    @(posedge aclk);
    fld <= o;
    issue_valid <= 1'h1;
    #1;
    a = (o.fi == SP_INDEX) ? i_rf.sp : i_rf.regs[o.fi];
    b = (o.si == SP_INDEX) ? 64'h0 : i_rf.regs[o.si];
    n = 8 << o.opt[1:0];
    m = (n == 64) ? '1 : (64'h1 << n) - 64'h1;
    b = (o.opt[2] && n < 64 && b[n-1]) ? (b | ~m) : (b & m);
    b = o.imf ? ({52'h0, o.imm} << (o.ish ? 12 : 0)) : (b << o.sa);
    e = (a + ~b + 64'h1) & (o.ws ? '1 : NARROW_MASK);
    und = !o.imf && (o.sa > MAX_EXT_SHIFT);
    @(posedge aclk);
    issue_valid <= 1'h0;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (!wb_valid && n < 8);
    check(64'(n), 64'(LATENCY));
    check(64'(wb_undefined), 64'(und));
    check(64'(wb_write_enable), 64'(!und));
    check(64'(wb_to_stack_pointer), 64'(!und && o.di == SP_INDEX));
    if (!und)
    begin
      check(64'(wb_dest_index), 64'(o.di));
      check(wb_result, e);
      last_res = e;
      def_cnt++;
    end
  endtask
  // ************************************************
  // tests
  // ************************************************
  initial
  begin
    #400000;
    err_total++;
    complete_run();
  end
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    reg_io(1'h0, CTRL_OFFSET, 32'h0, 32'h1, RESP_OKAY);
    reg_io(1'h0, MASK_OFFSET, 32'h0, 32'h0, RESP_OKAY);
    reg_io(1'h0, STATUS_OFFSET, 32'h0, 32'h0, RESP_OKAY);
    reg_io(1'h0, 8'h40, 32'h0, 32'h0, RESP_SLVERR);
    reg_io(1'h1, 8'h40, 32'h3, 32'h0, RESP_SLVERR);
    for (int w = 0; w < 2; w++)
      for (int i = 0; i < 8; i++)
        do_op('{1'h0, w[0], i[2:0], 3'((i + w) % 5), 12'h0, 1'h0, 5'(i + 1), 5'(i + 9), 5'(i + 2)});
    for (int k = 0; k < 10; k++)
      do_op(spec[k]);
    reg_io(1'h0, STATUS_OFFSET, 32'h0, 32'h3, RESP_OKAY);
    reg_io(1'h0, COUNT_OFFSET, 32'h0, 32'(def_cnt), RESP_OKAY);
    reg_io(1'h0, RESULT_LO_OFFSET, 32'h0, last_res[31:0], RESP_OKAY);
    reg_io(1'h0, RESULT_HI_OFFSET, 32'h0, last_res[63:32], RESP_OKAY);
    check(64'(irq), 64'h0);
    reg_io(1'h1, MASK_OFFSET, 32'h1, 32'h0, RESP_OKAY);
    check(64'(irq), 64'h1);
    reg_io(1'h1, STATUS_OFFSET, 32'h1, 32'h0, RESP_OKAY);
    check(64'(irq), 64'h0);
    reg_io(1'h0, STATUS_OFFSET, 32'h0, 32'h2, RESP_OKAY);
    reg_io(1'h1, MASK_OFFSET, 32'h3, 32'h0, RESP_OKAY);
    check(64'(irq), 64'h1);
    reg_io(1'h1, STATUS_OFFSET, 32'h2, 32'h0, RESP_OKAY);
    check(64'(irq), 64'h0);
    reg_io(1'h1, CTRL_OFFSET, 32'h0, 32'h0, RESP_OKAY);
    check(64'(issue_ready), 64'h0);
    @(posedge aclk);
    issue_valid <= 1'h1;
    repeat (4) @(posedge aclk);
    issue_valid <= 1'h0;
    reg_io(1'h0, COUNT_OFFSET, 32'h0, 32'(def_cnt), RESP_OKAY);
    reg_io(1'h1, CTRL_OFFSET, 32'h3, 32'h0, RESP_OKAY);
    reg_io(1'h0, CTRL_OFFSET, 32'h0, 32'h3, RESP_OKAY);
    do_op(spec[6]);
    do_op(spec[3]);
    complete_run();
  end
endmodule // test_subtract_extended_immediate_unit
